// [rtl/ehsts_pkg.sv]
// Purpose: Shared constants and carrier types for the host status register block
// Assumes: 32-bit register access, byte address offsets relative to the memory base
// Notes:   Bit positions follow the status and command register layouts
package ehsts_pkg;

    // Register addressing
    localparam logic [7:0]  HOST_STATUS_OFS   = 8'h24;
    localparam logic [7:0]  MEM_BASE_CFG_OFS  = 8'h10;

    // Status register field positions
    localparam int TRANSFER_DONE_BIT   = 0;
    localparam int TRANSFER_ERROR_BIT  = 1;
    localparam int PORT_CHANGE_BIT     = 2;
    localparam int FRAME_WRAP_BIT      = 3;
    localparam int HOST_SYS_ERROR_BIT  = 4;
    localparam int ASYNC_ADVANCE_BIT   = 5;
    localparam int HALTED_BIT          = 12;
    localparam int EMPTY_DETECT_BIT    = 13;
    localparam int PERIODIC_STATE_BIT  = 14;
    localparam int ASYNC_STATE_BIT     = 15;

    // Command register field positions
    localparam int RUN_CONTROL_BIT     = 0;
    localparam int PERIODIC_EN_BIT     = 4;
    localparam int ASYNC_EN_BIT        = 5;

    // Reset values
    localparam logic [5:0]  FLAGS_RESET       = 6'h00;
    localparam logic        HALTED_RESET      = 1'b1;

    // Schedule state lag in clock cycles and the width of its lag counter
    localparam int SCHED_LAG_CYCLES  = 4;
    localparam int LAG_CNT_W         = 4;

    // Event sources from the controller core
    typedef struct packed {
        logic async_advance;
        logic host_sys_error;
        logic frame_wrap;
        logic port_change;
        logic transfer_error;
        logic transfer_done;
    } ehsts_events_t;

    // Register access request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ehsts_req_t;

    // Controller control state
    typedef enum logic [1:0] {
        ST_HALTED,
        ST_RUNNING,
        ST_DRAINING
    } ehsts_run_t;

endpackage

// [rtl/ehsts_sched_track.sv]
// Purpose: Tracks one schedule's actual state, following its enable after a lag
// Assumes: Enable comes from logic on the same clock
// Notes:   State only changes while the controller is not halted
`timescale 1ns/1ps
`default_nettype none
module ehsts_sched_track #(
    parameter int LAG = ehsts_pkg::SCHED_LAG_CYCLES
) (
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rstn,
    // Control
    input  wire logic i_enable,
    input  wire logic i_running,
    // Status
    output logic      o_state
);
    typedef struct packed {
        logic                           state;
        logic [ehsts_pkg::LAG_CNT_W-1:0] cnt;
    } ehsts_trk_t;

    // Last count of the lag; the counter is wide enough for lags up to sixteen
    localparam int                CNT_W = ehsts_pkg::LAG_CNT_W;
    localparam logic [CNT_W-1:0]  LAST  = CNT_W'(LAG - 1);

    ehsts_trk_t s_q, s_d;

    // Count the lag before following the enable; leaving running forgets any partial lag
    always_comb begin
        s_d = s_q;
        if (!i_running) begin
            s_d.state = 1'b0;
            s_d.cnt   = '0;
        end else if (i_enable != s_q.state) begin
            if (s_q.cnt == LAST) begin
                s_d.state = i_enable;
                s_d.cnt   = '0;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end else begin
            s_d.cnt = '0;
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_state = s_q.state;
endmodule
`default_nettype wire

// [rtl/ehsts_status.sv]
// Purpose: Host status register with schedule states, halt tracking and clearable flags
// Assumes: Register port decoded at offset within the controller memory window
// Notes:   Run control is held here so a system error can clear it directly
//          A flag event that meets its own clear in one cycle stays set
//          Schedule states drop to idle as soon as the controller leaves running
//          Only the status word offset answers; other offsets stay silent
`timescale 1ns/1ps
`default_nettype none
module ehsts_status #(
    parameter int LAG = ehsts_pkg::SCHED_LAG_CYCLES
) (
    // Clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_rstn,
    // Register access
    input  wire ehsts_pkg::ehsts_req_t i_req,
    output logic [31:0]                o_rdata,
    output logic                       o_rvalid,
    // Command bits from the command register
    input  wire logic                  i_run_set,
    input  wire logic                  i_run_clr,
    input  wire logic                  i_async_sched_enable,
    input  wire logic                  i_periodic_sched_enable,
    // Core events and pipeline state
    input  wire ehsts_pkg::ehsts_events_t i_events,
    input  wire logic                  i_pipe_busy,
    input  wire logic                  i_async_empty,
    // Controller state
    output logic                       o_run_control,
    output logic                       o_controller_halted,
    output logic                       o_async_sched_state,
    output logic                       o_periodic_sched_state
);
    // Block state:
    //   run_st      - halted, running or draining the pipeline
    //   run_control - run request as seen by the core
    //   halted      - stopped indication shown in the status word
    //   empty_det   - empty asynchronous schedule seen while it runs
    //   flags       - write-one-to-clear event flags
    //   rdata       - read answer, held until the next read
    typedef struct packed {
        ehsts_pkg::ehsts_run_t run_st;
        logic                  run_control;
        logic                  halted;
        logic                  empty_det;
        logic [5:0]            flags;
        logic [31:0]           rdata;
        logic                  rvalid;
    } ehsts_state_t;

    ehsts_state_t s_q, s_d;
    logic         async_st;
    logic         per_st;
    logic         running;
    logic         rd_hit;
    logic         wr_hit;
    logic [31:0]  rd_word;

    // True while the controller executes its schedules
    function automatic logic run_active(input ehsts_pkg::ehsts_run_t st);
        run_active = (st == ehsts_pkg::ST_RUNNING);
    endfunction

    // True when a request addresses the status word
    function automatic logic status_hit(input logic [7:0] addr);
        status_hit = (addr == ehsts_pkg::HOST_STATUS_OFS);
    endfunction

    // Flag update: ones in the write mask clear, a fresh event sets again.
    // Setting last means an event that lands with its own clear is never lost.
    function automatic logic [5:0] flag_next(
        input logic [5:0] cur,
        input logic       clr_en,
        input logic [5:0] clr_mask,
        input logic [5:0] set_mask
    );
        logic [5:0] kept;
        kept      = clr_en ? (cur & ~clr_mask) : cur;
        flag_next = kept | set_mask;
    endfunction

    // Halted shows only once the machine has stopped and no run is pending
    function automatic logic halt_view(
        input ehsts_pkg::ehsts_run_t st,
        input logic                  run
    );
        halt_view = (st == ehsts_pkg::ST_HALTED) && !run;
    endfunction

    // Request decode, shared by read capture and flag clearing
    always_comb begin
        running = run_active(s_q.run_st);
        rd_hit  = i_req.rd && status_hit(i_req.addr);
        wr_hit  = i_req.wr && status_hit(i_req.addr);
    end

    // Schedule state trackers; a schedule can only be active while the
    // controller runs, so both drop to idle once it drains or halts
    ehsts_sched_track #(.LAG(LAG)) u_async (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_enable (i_async_sched_enable),
        .i_running(running),
        .o_state  (async_st)
    );
    ehsts_sched_track #(.LAG(LAG)) u_per (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_enable (i_periodic_sched_enable),
        .i_running(running),
        .o_state  (per_st)
    );

    // Read word assembly: states in 15-12, flags in 5-0;
    // reserved positions and per-transaction results never show up,
    // so they read as zero whatever software wrote there
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_word[ehsts_pkg::ASYNC_STATE_BIT]    = async_st;
        rd_word[ehsts_pkg::PERIODIC_STATE_BIT] = per_st;
        rd_word[ehsts_pkg::EMPTY_DETECT_BIT]   = s_q.empty_det;
        rd_word[ehsts_pkg::HALTED_BIT]         = s_q.halted;
        rd_word[5:0]                           = s_q.flags;
    end

    // Next-state logic
    always_comb begin
        s_d        = s_q;
        // Read answer: one-cycle valid, data held until the next read
        s_d.rvalid = rd_hit;
        if (rd_hit) begin
            s_d.rdata = rd_word;
        end
        // Flags: write one clears, new event wins; bits 15-12 ignore writes
        s_d.flags = flag_next(s_q.flags, wr_hit, i_req.wdata[5:0], i_events);
        // Empty-schedule flag only means something while the async schedule runs
        s_d.empty_det = i_async_empty && async_st;
        // Run control and halt sequencing; a clear or a system error wins
        // over a set in the same cycle, so a faulting controller never
        // keeps running
        if (i_run_set) begin
            s_d.run_control = 1'b1;
        end
        if (i_run_clr || i_events.host_sys_error) begin
            s_d.run_control = 1'b0;
        end
        case (s_q.run_st)
            // Stopped: wait for a run request
            ehsts_pkg::ST_HALTED: begin
                if (s_d.run_control) begin
                    s_d.run_st = ehsts_pkg::ST_RUNNING;
                end
            end
            // Executing: a cleared run bit starts the drain
            ehsts_pkg::ST_RUNNING: begin
                if (!s_d.run_control) begin
                    s_d.run_st = ehsts_pkg::ST_DRAINING;
                end
            end
            // Draining: active transactions finish before the halt shows
            ehsts_pkg::ST_DRAINING: begin
                if (s_d.run_control) begin
                    s_d.run_st = ehsts_pkg::ST_RUNNING;
                end else if (!i_pipe_busy) begin
                    s_d.run_st = ehsts_pkg::ST_HALTED;
                end
            end
            default: begin
                s_d.run_st = ehsts_pkg::ST_HALTED;
            end
        endcase
        // Halted only once stopped, never while running requested
        s_d.halted = halt_view(s_d.run_st, s_d.run_control);
    end

    // State register; reset loads halted high so software first sees a
    // stopped controller
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q.run_st      <= ehsts_pkg::ST_HALTED;
            s_q.run_control <= 1'b0;
            s_q.halted      <= ehsts_pkg::HALTED_RESET;
            s_q.empty_det   <= 1'b0;
            s_q.flags       <= ehsts_pkg::FLAGS_RESET;
            s_q.rdata       <= 32'h0000_0000;
            s_q.rvalid      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata                = s_q.rdata;
    assign o_rvalid               = s_q.rvalid;
    assign o_run_control          = s_q.run_control;
    assign o_controller_halted    = s_q.halted;
    assign o_async_sched_state    = async_st;
    assign o_periodic_sched_state = per_st;
endmodule
`default_nettype wire

// [testbench/ehsts_status_assertions.sv]
// Purpose: Port-level assertions for the host status register
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound into every status block instance
`timescale 1ns/1ps
`default_nettype none
module ehsts_status_assertions #(
    parameter int LAG = 4
) (
    // Clock and reset
    input wire logic                     i_mclk,
    input wire logic                     i_rstn,
    // Inputs seen by the block
    input wire ehsts_pkg::ehsts_req_t    i_req,
    input wire logic                     i_run_set,
    input wire logic                     i_run_clr,
    input wire logic                     i_async_sched_enable,
    input wire logic                     i_periodic_sched_enable,
    input wire ehsts_pkg::ehsts_events_t i_events,
    input wire logic                     i_pipe_busy,
    // Outputs of the block
    input wire logic [31:0]              o_rdata,
    input wire logic                     o_rvalid,
    input wire logic                     o_run_control,
    input wire logic                     o_controller_halted,
    input wire logic                     o_async_sched_state,
    input wire logic                     o_periodic_sched_state
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // Steps of a status read and of a drain
    sequence s_read; i_req.rd && i_req.addr == 8'h24; endsequence
    sequence s_drain; !o_run_control && !o_controller_halted && !i_run_set; endsequence
    property s_draining_busy;
        s_drain ##0 i_pipe_busy |=> !o_controller_halted;
    endproperty
    read_answer_a: assert property (s_read |=> o_rvalid)
        else $error("read of status gave no answer");
    answer_cause_a: assert property (o_rvalid |-> $past(i_req.rd && i_req.addr == 8'h24))
        else $error("answer without status read");
    reserved_zero_a: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000 && o_rdata[11:6] == 6'h00)
        else $error("reserved bits read nonzero");
    run_not_halted_a: assert property (o_run_control |-> !o_controller_halted)
        else $error("halted while running");
    drain_wait_a: assert property (s_draining_busy)
        else $error("halted with pipeline busy");
    drain_done_a: assert property (s_drain ##0 !i_pipe_busy |=> o_controller_halted)
        else $error("no halt after drain");
    sys_err_stop_a: assert property (i_events.host_sys_error |=> !o_run_control)
        else $error("system error left run set");
    async_follow_a: assert property ($rose(o_async_sched_state) |-> $past(i_async_sched_enable))
        else $error("async state rose while disabled");
    periodic_follow_a: assert property ($rose(o_periodic_sched_state) |-> $past(i_periodic_sched_enable))
        else $error("periodic state rose while disabled");
endmodule
bind ehsts_status ehsts_status_assertions #(.LAG(LAG)) ehsts_status_assertions_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(i_req), .i_run_set(i_run_set),
    .i_run_clr(i_run_clr), .i_async_sched_enable(i_async_sched_enable),
    .i_periodic_sched_enable(i_periodic_sched_enable), .i_events(i_events),
    .i_pipe_busy(i_pipe_busy), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .o_run_control(o_run_control), .o_controller_halted(o_controller_halted),
    .o_async_sched_state(o_async_sched_state), .o_periodic_sched_state(o_periodic_sched_state));
`default_nettype wire

// [testbench/ehsts_status_tb.sv]
// Purpose: Self-checking bench for the host status register
// Assumes: Inputs driven on the falling clock edge
// Notes:   Lag parameter kept at four cycles
`timescale 1ns/1ps
`default_nettype none
module ehsts_status_tb;
    logic                     i_mclk = 1'b0;
    logic                     i_rstn = 1'b0;
    ehsts_pkg::ehsts_req_t    req    = '0;
    ehsts_pkg::ehsts_events_t ev     = '0;
    logic                     rs_set = 1'b0, rs_clr = 1'b0, a_en = 1'b0, p_en = 1'b0;
    logic                     busy   = 1'b0, empty = 1'b0;
    logic [31:0]              rdata;
    logic                     rvalid, run, halted;
    logic                     a_st, p_st;
    int                       failures = 0, n_checks = 0, cyc = 0;
    ehsts_status #(.LAG(4)) ehsts_status_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_req(req),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_run_set(rs_set), .i_run_clr(rs_clr),
        .i_async_sched_enable(a_en), .i_periodic_sched_enable(p_en), .i_events(ev),
        .i_pipe_busy(busy), .i_async_empty(empty), .o_run_control(run),
        .o_controller_halted(halted), .o_async_sched_state(a_st),
        .o_periodic_sched_state(p_st));
    // Clock and hang guard
    initial begin
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_mclk);
    endtask
    // One-cycle register read, answer checked on the next falling edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        req.rd = 1'b1;
        req.addr = a;
        tick(1);
        req.rd = 1'b0;
        chk({31'h0, rvalid}, {31'h0, a == 8'h24});
        if (a == 8'h24) chk(rdata, exp);
    endtask
    // One-cycle write to the status word
    task automatic wr(input logic [31:0] d);
        req.wr = 1'b1;
        req.addr = 8'h24;
        req.wdata = d;
        tick(1);
        req.wr = 1'b0;
    endtask
    // Poll the halted output for a bounded number of cycles
    task automatic wait_halt();
        for (int k = 0; k < 10 && halted !== 1'b1; k++) tick(1);
        chk({31'h0, halted}, 32'h1);
    endtask
    // Start, let both schedules follow their enables, then stop the async one
    task automatic t_sched();
        rs_set = 1'b1;
        tick(1);
        rs_set = 1'b0;
        chk({31'h0, halted}, 32'h0);
        chk({31'h0, run}, 32'h1);
        a_en = 1'b1;
        p_en = 1'b1;
        tick(3);
        chk({30'h0, a_st, p_st}, 32'h0);
        tick(3);
        chk({30'h0, a_st, p_st}, 32'h3);
        rd(8'h24, 32'h0000C000);
        empty = 1'b1;
        tick(2);
        rd(8'h24, 32'h0000E000);
        wr(32'h0000F000);
        rd(8'h24, 32'h0000E000);
        a_en = 1'b0;
        tick(3);
        chk({30'h0, a_st, p_st}, 32'h3);
        tick(3);
        chk({30'h0, a_st, p_st}, 32'h1);
        rd(8'h24, 32'h00004000);
    endtask
    // Raise flags, clear them by ones, then clear and set one flag together
    task automatic t_flags();
        ev = 6'h2F;
        tick(1);
        ev = '0;
        rd(8'h24, 32'h0000402F);
        wr(32'h00000001);
        rd(8'h24, 32'h0000402E);
        wr(32'h0000002E);
        rd(8'h24, 32'h00004000);
        ev = 6'h01;
        wr(32'h00000001);
        ev = '0;
        rd(8'h24, 32'h00004001);
        wr(32'h00000001);
        rd(8'h24, 32'h00004000);
    endtask
    // Clear run with a busy pipeline and watch the drain end in a halt
    task automatic t_halt();
        busy = 1'b1;
        rs_clr = 1'b1;
        tick(1);
        rs_clr = 1'b0;
        tick(4);
        chk({31'h0, halted}, 32'h0);
        busy = 1'b0;
        wait_halt();
        chk({30'h0, a_st, p_st}, 32'h0);
        rd(8'h24, 32'h00001000);
    endtask
    // A system error stops the controller by itself; other offsets stay silent
    task automatic t_syserr();
        rs_set = 1'b1;
        tick(1);
        rs_set = 1'b0;
        ev = 6'h10;
        tick(1);
        ev = '0;
        chk({31'h0, run}, 32'h0);
        wait_halt();
        rd(8'h24, 32'h00001010);
        tick(1);
        rd(8'h28, 32'h00000000);
    endtask
    // Print the counts and the verdict, then end the run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(3);
        i_rstn = 1'b1;
        chk({29'h0, run, a_st, p_st}, 32'h0);
        rd(8'h24, 32'h00001000);
        t_sched();
        t_flags();
        t_halt();
        t_syserr();
        wrap_up();
    end
endmodule
`default_nettype wire
